// ---- logic/acc_pkg.sv ----
// package: register map, field positions, reset values and carriers for the comparator control block
// ****************************************************************************
// Functional notes
// - two-bit select picks one of four negative pins
// - analog pins read zero on port read
// - result bit six is raw xor invert
// - pin output when enabled and direction clear
// - pwm shutdown may use either or both results
// - auto-restart gives closed loop pwm feedback
// - sync latches result on timer clock fall
// - edge with matching enable sets interrupt flag
// - disabled forces raw result zero, inputs disconnected
// - internal result latched every instruction cycle
// ****************************************************************************
package acc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL0_OFS    = 8'h00;   // comparator_control_zero
  localparam logic [7:0] CTRL1_OFS    = 8'h04;   // edge enables, negative select
  localparam logic [7:0] FLAG_OFS     = 8'h08;   // interrupt flag, write one to clear
  localparam logic [7:0] PORT_OFS     = 8'h0C;   // port data readback
  localparam logic [7:0] ANALOG_SELECT_REG_OFS    = 8'h10;   // analog_select_reg
  localparam logic [7:0] DIR_OFS      = 8'h14;   // pin_direction_reg
  localparam logic [7:0] PWM_OFS      = 8'h18;   // shutdown source selection
  // control zero fields
  localparam int EN_BIT   = 7;
  localparam int RES_BIT  = 6;
  localparam int OE_BIT   = 5;
  localparam int INV_BIT  = 4;
  localparam int SP_BIT   = 2;
  localparam int HYS_BIT  = 1;
  localparam int SYNC_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h04;    // speed bit set
  localparam logic [7:0] CTRL0_WMASK = 8'hB7;    // result and bit three not writable
  // control one fields
  localparam int RISE_BIT = 7;
  localparam int FALL_BIT = 6;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  // pin map within the port: result pin and four negative pins
  localparam int PORT_W       = 8;
  localparam int RES_PIN      = 4;
  localparam logic [7:0] ANALOG_SELECT_REG_RESET = 8'h0F;    // negative pins analog out of reset
  localparam logic [7:0] DIR_RESET   = 8'hFF;    // all pins inputs
  // pwm source fields
  localparam int SD_SRC0_BIT = 0;
  localparam int SD_SRC1_BIT = 1;
  localparam int SD_EN_BIT   = 2;
  localparam int RESTART_BIT = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // shutdown command to the pwm logic
  typedef struct packed {
    logic shutdown;     // hold pwm outputs off
    logic restart;      // release when sources clear
  } acc_pwm_s;
endpackage

// ---- logic/acc_edge_flag.sv ----
// edge detector and sticky interrupt flag for the comparator result
`timescale 1ns/1ps
module acc_edge_flag (
  input  wire logic aclk,        // clock
  input  wire logic aresetn,     // sync reset, low
  input  wire logic result,      // latched result
  input  wire logic rise_en,     // rising edge enable
  input  wire logic fall_en,     // falling edge enable
  input  wire logic clear,       // software clear pulse
  output logic      flag         // sticky flag
);
  logic prev;                    // result one cycle ago

  // remember last result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= result;
    end
  end

  // set beats clear so an edge in the clear cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if ((rise_en && result && !prev) || (fall_en && !result && prev)) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

// ---- logic/acc_top.sv ----
// comparator control: registers, input select, result latch, pin and pwm outputs
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module acc_top (
  input  wire logic                       aclk,           // 250 MHz clock
  input  wire logic                       aresetn,        // sync reset, low
  input  wire logic [7:0]                 s_axi_awaddr,   // write address
  input  wire logic                       s_axi_awvalid,  // write address valid
  output logic                            s_axi_awready,  // write address ready
  input  wire logic [31:0]                s_axi_wdata,    // write data
  input  wire logic [3:0]                 s_axi_wstrb,    // byte strobes
  input  wire logic                       s_axi_wvalid,   // write data valid
  output logic                            s_axi_wready,   // write data ready
  output logic [1:0]                      s_axi_bresp,    // write response
  output logic                            s_axi_bvalid,   // write response valid
  input  wire logic                       s_axi_bready,   // write response ready
  input  wire logic [7:0]                 s_axi_araddr,   // read address
  input  wire logic                       s_axi_arvalid,  // read address valid
  output logic                            s_axi_arready,  // read address ready
  output logic [31:0]                     s_axi_rdata,    // read data
  output logic [1:0]                      s_axi_rresp,    // read response
  output logic                            s_axi_rvalid,   // read data valid
  input  wire logic                       s_axi_rready,   // read data ready
  input  wire logic                       cmp_raw,        // analog compare, 1 when positive above negative
  input  wire logic [acc_pkg::PORT_W-1:0] pin_in,         // digital pin levels
  input  wire logic                       timer_clk_src,  // timer clock after prescaler
  input  wire logic                       other_result,   // second comparator result
  output logic [3:0]                      neg_input_select_onehot, // negative pin switches
  output logic                            cmp_power,      // analog enable
  output logic                            speed_power_select, // speed mode to analog
  output logic                            hysteresis_enable,  // hysteresis to analog
  output logic                            first_result_pin,   // result pin level
  output logic                            first_result_pin_oe,// result pin drive enable
  output logic                            cmp_result_async,   // result to pwm logic
  output logic                            cmp_result_sync,    // result to timer gate
  output acc_pkg::acc_pwm_s               pwm_ctrl,       // shutdown command
  output logic                            cmp_interrupt_flag  // sticky flag
);
  // ****************************************************************************
  // registers
  // ****************************************************************************
  logic [7:0]                 ctrl0;       // comparator_control_zero, writable bits
  logic [7:0]                 ctrl1;       // edge enables and select
  logic [7:0]                 analog_select_reg; // analog pin select
  logic [7:0]                 pin_direction_reg; // 1 = input
  logic [3:0]                 pwm_cfg;     // shutdown configuration
  logic                       cmp_result;  // latched polarity-adjusted result
  logic                       tclk_prev;   // timer clock last cycle
  logic                       flag_clear;  // write-one clear pulse
  logic                       aw_held;     // write address captured
  logic                       w_held;      // write data captured
  logic [7:0]                 aw_addr;     // captured write address
  logic [31:0]                w_data;      // captured write data
  logic [3:0]                 w_strb;      // captured strobes

  // masked read of a port: analog pins read zero
  function automatic logic [7:0] port_view(input logic [7:0] pins, input logic [7:0] ana);
    port_view = pins & ~ana;
  endfunction

  // ****************************************************************************
  // analog side
  // ****************************************************************************
  // raw bit is forced low and switches opened while disabled
  logic raw_gated;                                            // raw after enable gate
  logic polar;                                                // after polarity
  always_comb begin
    cmp_power = ctrl0[acc_pkg::EN_BIT];
    raw_gated = cmp_raw & ctrl0[acc_pkg::EN_BIT];
    polar     = raw_gated ^ ctrl0[acc_pkg::INV_BIT];
    neg_input_select_onehot = 4'h0;
    if (ctrl0[acc_pkg::EN_BIT]) begin
      neg_input_select_onehot[ctrl1[1:0]] = 1'b1;
    end
    speed_power_select = ctrl0[acc_pkg::SP_BIT];
    hysteresis_enable  = ctrl0[acc_pkg::HYS_BIT];
  end

  // result latched every cycle for reads, flag and pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_result <= 1'b0;
    end else begin
      cmp_result <= polar;
    end
  end

  // timer sync: sample on the falling edge of the timer clock source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tclk_prev       <= 1'b0;
      cmp_result_sync <= 1'b0;
    end else begin
      tclk_prev <= timer_clk_src;
      if (!ctrl0[acc_pkg::SYNC_BIT]) begin
        cmp_result_sync <= cmp_result;                        // asynchronous mode follows
      end else if (tclk_prev && !timer_clk_src) begin
        cmp_result_sync <= cmp_result;
      end
    end
  end

  // pin output: enable bit and cleared direction; not affected by enable
  always_comb begin
    first_result_pin    = ctrl0[acc_pkg::SYNC_BIT] ? cmp_result_sync : cmp_result;
    first_result_pin_oe = ctrl0[acc_pkg::OE_BIT] & ~pin_direction_reg[acc_pkg::RES_PIN];
    cmp_result_async    = cmp_result;
  end

  // pwm shutdown from either or both results; restart closes the loop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_ctrl <= '0;
    end else begin
      pwm_ctrl.shutdown <= pwm_cfg[acc_pkg::SD_EN_BIT] &
                           ((pwm_cfg[acc_pkg::SD_SRC0_BIT] & cmp_result) |
                            (pwm_cfg[acc_pkg::SD_SRC1_BIT] & other_result));
      pwm_ctrl.restart  <= pwm_cfg[acc_pkg::SD_EN_BIT] & pwm_cfg[acc_pkg::RESTART_BIT];
    end
  end

  // result is only meaningful after software checks it; flag tracks edges
  acc_edge_flag u_flag (
    .aclk    (aclk),
    .aresetn (aresetn),
    .result  (cmp_result),                                    // latched result feeds the edge detector
    .rise_en (ctrl1[acc_pkg::RISE_BIT]),
    .fall_en (ctrl1[acc_pkg::FALL_BIT]),
    .clear   (flag_clear),
    .flag    (cmp_interrupt_flag)
  );

  // ****************************************************************************
  // axi4-lite write
  // ****************************************************************************
  logic do_write;                                             // both halves held, no response pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // register updates; only byte lane zero holds data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0             <= acc_pkg::CTRL0_RESET;
      ctrl1             <= acc_pkg::CTRL1_RESET;
      analog_select_reg <= acc_pkg::ANALOG_SELECT_REG_RESET;              // negative pins analog out of reset
      pin_direction_reg <= acc_pkg::DIR_RESET;
      pwm_cfg           <= 4'h0;
    end else if (do_write && w_strb[0]) begin
      unique case ({aw_addr[7:2], 2'b00})
        acc_pkg::CTRL0_OFS: ctrl0 <= w_data[7:0] & acc_pkg::CTRL0_WMASK;
        acc_pkg::CTRL1_OFS: ctrl1 <= w_data[7:0];
        acc_pkg::ANALOG_SELECT_REG_OFS: analog_select_reg <= w_data[7:0];
        acc_pkg::DIR_OFS:   pin_direction_reg <= w_data[7:0];
        acc_pkg::PWM_OFS:   pwm_cfg <= w_data[3:0];
        default: ;                                            // read-only or unmapped
      endcase
    end
  end

  // write-one clear of the flag
  assign flag_clear = do_write && w_strb[0] && ({aw_addr[7:2], 2'b00} == acc_pkg::FLAG_OFS) && w_data[0];

  // response: okay on mapped offsets, slverr elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ({aw_addr[7:2], 2'b00} <= acc_pkg::PWM_OFS) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************************
  // axi4-lite read
  // ****************************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // read mux, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= acc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= acc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        acc_pkg::CTRL0_OFS: s_axi_rdata[7:0] <= ctrl0 | ({7'h00, cmp_result} << acc_pkg::RES_BIT);
        acc_pkg::CTRL1_OFS: s_axi_rdata[7:0] <= ctrl1;
        acc_pkg::FLAG_OFS:  s_axi_rdata[0]   <= cmp_interrupt_flag;
        acc_pkg::PORT_OFS:  s_axi_rdata[7:0] <= port_view(pin_in, analog_select_reg);
        acc_pkg::ANALOG_SELECT_REG_OFS: s_axi_rdata[7:0] <= analog_select_reg;
        acc_pkg::DIR_OFS:   s_axi_rdata[7:0] <= pin_direction_reg;
        acc_pkg::PWM_OFS:   s_axi_rdata[3:0] <= pwm_cfg;
        default:            s_axi_rresp      <= acc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- test/acc_analog_model.sv ----
// far side model: analog levels behind the select switches and the timer clock
`timescale 1ns/1ps
module acc_analog_model (
  input  wire logic        aclk,                    // clock
  input  wire logic [3:0]  neg_input_select_onehot, // switch closures
  input  wire logic [7:0]  pos_level,               // positive input level
  input  wire logic [31:0] neg_levels,              // four negative pin levels
  input  wire logic        tclk_run,                // timer clock runs
  output logic             cmp_raw,                 // compare result
  output logic             timer_clk_src            // timer clock
);
  logic [7:0] sel_lvl;    // level on the closed switch
  logic [1:0] div = 2'd0; // timer divider, stands still when stopped
  // ****************************************************************
  // input selection and compare
  // ****************************************************************
  always_comb begin
    sel_lvl = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (neg_input_select_onehot[i]) sel_lvl = neg_levels[i*8 +: 8];
    end
  end
  // no switch closed means the inputs are cut off, so the output sits low
  assign cmp_raw = (|neg_input_select_onehot) && (pos_level > sel_lvl);
  always_ff @(posedge aclk) begin
    if (tclk_run) div <= div + 2'd1;
  end
  assign timer_clk_src = ~div[1]; // high while stopped
endmodule

// ---- test/acc_properties.sv ----
// checker: bus timing and result timing at the block's ports
`timescale 1ns/1ps
module acc_properties (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic        cmp_raw,
  input logic [3:0]  neg_input_select_onehot,
  input logic        cmp_power,
  input logic        cmp_result_async,
  input logic        cmp_interrupt_flag
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sel_onehot; cmp_power |-> $onehot(neg_input_select_onehot); endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("select not one-hot");
  property p_sel_off; !cmp_power |-> neg_input_select_onehot == 4'h0; endproperty
  a_sel_off: assert property (p_sel_off) else $error("switch closed while off");
  // a write response marks a control change, the only other cause of a result change
  property p_res_cause;
    $changed(cmp_result_async) && !$past(s_axi_bvalid) |-> $past(cmp_raw) != $past(cmp_raw, 2);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("result moved without cause");
  property p_flag_edge;
    $rose(cmp_interrupt_flag) |-> $past(cmp_result_async) != $past(cmp_result_async, 2);
  endproperty
  a_flag_edge: assert property (p_flag_edge) else $error("flag without result edge");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
  c_flag: cover property ($rose(cmp_interrupt_flag));
  c_write: cover property (s_axi_bvalid);
  c_read: cover property (s_axi_rvalid);
endmodule
bind acc_top acc_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .cmp_raw,
  .neg_input_select_onehot, .cmp_power, .cmp_result_async, .cmp_interrupt_flag);

// ---- test/acc_top_tb.sv ----
// testbench: register scenarios over axi4-lite with the analog model on the far side
`timescale 1ns/1ps
module acc_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tclk_run;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmp_raw, timer_clk_src;
  logic other_result, cmp_power, speed_power_select, hysteresis_enable, first_result_pin;
  logic first_result_pin_oe, cmp_result_async, cmp_result_sync, cmp_interrupt_flag;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_in, pos_level;
  logic [31:0] s_axi_wdata, s_axi_rdata, neg_levels, rd_d;
  logic [3:0]  s_axi_wstrb, neg_input_select_onehot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  acc_pkg::acc_pwm_s pwm_ctrl; // shutdown command
  int failures, checks_done;
  acc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw, .pin_in,
    .timer_clk_src, .other_result, .neg_input_select_onehot, .cmp_power, .speed_power_select,
    .hysteresis_enable, .first_result_pin, .first_result_pin_oe, .cmp_result_async, .cmp_result_sync,
    .pwm_ctrl, .cmp_interrupt_flag);
  acc_analog_model u_far (.aclk, .neg_input_select_onehot, .pos_level, .neg_levels, .tclk_run, .cmp_raw,
    .timer_clk_src);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounds every wait: a stuck slave ends the run
  task automatic tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 40) begin
      failures++;
      results();
    end
  endtask
  // ready is looked at on the falling edge, where it has settled for the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      tick(n);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      rd_r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ah, done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      tick(n);
      ah = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tclk_run, other_result} = 5'h00;
    {s_axi_bready, s_axi_rready} = 2'b11; // always ready for answers
    {s_axi_awaddr, s_axi_araddr, pos_level} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    neg_levels = 32'h4632_1E0A; // 70, 50, 30, 10
    pin_in = 8'h5A;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(acc_pkg::CTRL0_OFS, 32'h0000_0004);
    chk({cmp_power, speed_power_select, hysteresis_enable, neg_input_select_onehot}, 32'h0000_0020);
    wr(acc_pkg::CTRL0_OFS, 32'h0000_00FE);
    chk(rd_r, acc_pkg::RESP_OKAY);
    rdc(acc_pkg::CTRL0_OFS, 32'h0000_00F6);
    chk({cmp_power, speed_power_select, hysteresis_enable, neg_input_select_onehot}, 32'h0000_0071);
    $display("test reset and control done");
    pos_level <= 8'd40;
    for (int i = 0; i < 4; i++) begin
      wr(acc_pkg::CTRL1_OFS, i);
      wr(acc_pkg::CTRL0_OFS, 32'h0000_0080);
      chk(neg_input_select_onehot, 32'h1 << i);
      rdc(acc_pkg::CTRL0_OFS, (i < 2) ? 32'h0000_00C0 : 32'h0000_0080);
      wr(acc_pkg::CTRL0_OFS, 32'h0000_0090);
      rdc(acc_pkg::CTRL0_OFS, (i < 2) ? 32'h0000_0090 : 32'h0000_00D0);
    end
    $display("test input select done");
    wr(acc_pkg::ANALOG_SELECT_REG_OFS, 32'h0000_000F);
    rdc(acc_pkg::PORT_OFS, 32'h0000_0050);
    wr(acc_pkg::ANALOG_SELECT_REG_OFS, 32'h0000_0000);
    rdc(acc_pkg::PORT_OFS, 32'h0000_005A);
    wr(acc_pkg::CTRL1_OFS, 32'h0000_0000);
    wr(acc_pkg::CTRL0_OFS, 32'h0000_00A0);
    wr(acc_pkg::DIR_OFS, 32'h0000_00EF);
    chk({first_result_pin_oe, first_result_pin}, 32'h0000_0003);
    wr(acc_pkg::DIR_OFS, 32'h0000_00FF);
    chk(first_result_pin_oe, 32'h0000_0000);
    $display("test port and pin done");
    rdc(acc_pkg::CTRL0_OFS, 32'h0000_00E0);
    wr(acc_pkg::PWM_OFS, 32'h0000_0005);
    // the shutdown command is registered one edge after the write lands
    @(negedge aclk);
    chk(pwm_ctrl.shutdown, 32'h0000_0001);
    @(posedge aclk);
    other_result <= 1'b1;
    wr(acc_pkg::PWM_OFS, 32'h0000_000E);
    @(negedge aclk);
    chk({pwm_ctrl.shutdown, pwm_ctrl.restart}, 32'h0000_0003);
    @(posedge aclk);
    $display("test pwm done");
    pos_level <= 8'd0;
    wr(acc_pkg::CTRL1_OFS, 32'h0000_0080);
    wr(acc_pkg::CTRL0_OFS, 32'h0000_0080);
    wr(acc_pkg::FLAG_OFS, 32'h0000_0001);
    pos_level <= 8'd200;
    repeat (4) @(posedge aclk);
    chk(cmp_interrupt_flag, 32'h0000_0001);
    wr(acc_pkg::FLAG_OFS, 32'h0000_0001);
    rdc(acc_pkg::FLAG_OFS, 32'h0000_0000);
    pos_level <= 8'd0;
    repeat (4) @(posedge aclk);
    chk(cmp_interrupt_flag, 32'h0000_0000);
    // falling edge enable alone: a rise must not flag, a fall must
    wr(acc_pkg::CTRL1_OFS, 32'h0000_0040);
    pos_level <= 8'd200;
    repeat (4) @(posedge aclk);
    chk(cmp_interrupt_flag, 32'h0000_0000);
    pos_level <= 8'd0;
    repeat (4) @(posedge aclk);
    chk(cmp_interrupt_flag, 32'h0000_0001);
    wr(acc_pkg::FLAG_OFS, 32'h0000_0001);
    $display("test flag done");
    wr(acc_pkg::CTRL0_OFS, 32'h0000_0081);
    pos_level <= 8'd200;
    repeat (4) @(posedge aclk);
    chk({cmp_result_async, first_result_pin, cmp_result_sync}, 32'h0000_0004);
    tclk_run <= 1'b1;
    repeat (12) @(posedge aclk);
    chk({first_result_pin, cmp_result_sync}, 32'h0000_0003);
    rd(8'h1C);
    chk(rd_r, acc_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h0000_0000);
    chk(rd_r, acc_pkg::RESP_SLVERR);
    $display("test sync and unmapped done");
    results();
  end
endmodule
